// ===== design/sched_pkg.sv
// Overview of operation
// R1 - Control enable acts from next frame
// R2 - Control enable sampled before every control service
// R3 - Software advances control pointer before re-enabling
// R4 - No control list access while disabled
// R5 - Iso descriptor met: continue if iso enabled
// R6 - Iso disabled: stop periodic, go nonperiodic
// R7 - Iso enable change acts next frame
// R8 - Periodic enable acts from next frame
// R9 - Periodic enable read before periodic walk
// R10 - Ratio compared with control count first
// R11 - Control count kept across frames
// R12 - Ratio codes give 1:1 to 4:1
// R13 - Software restores ratio after reset
// R14 - Frames follow SOF, first 1 ms after operational
// R15 - Ratio reached: one bulk, then clear count
`default_nettype none

package sched_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_LIST_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_CUR_PTR    = 12'h004;
    localparam logic [11:0] ADDR_SCHED_STAT = 12'h008;
    localparam int          RATIO_LSB       = 0;
    localparam int          PERIODIC_BIT    = 2;
    localparam int          ISO_BIT         = 3;
    localparam int          CTRL_BIT        = 4;
    localparam int          PTR_LSB         = 4;
    localparam logic [1:0]  RATIO_RST       = 2'h0;
    localparam logic [27:0] PTR_RST         = 28'h0000000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int SOF_DELAY_NS  = 1000000;
    localparam int FRAME_NS      = 1000000;
    localparam int SOF_DELAY_CYC = SOF_DELAY_NS / CLK_PERIOD_NS;
    localparam int FRAME_CYC     = FRAME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // List codes and scheduler states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LIST_PERIODIC = 2'h0,
        LIST_CTRL     = 2'h1,
        LIST_BULK     = 2'h2
    } list_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PER  = 4'h2,
        ST_NPER = 4'h4,
        ST_DONE = 4'h8
    } state_t;
endpackage : sched_pkg

`default_nettype wire

// ===== design/frame_timer.sv
`default_nettype none

module frame_timer #(
    parameter int START_CYC = 200000,
    parameter int FRAME_CYC = 200000
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic operational,
    output var  logic sof_r
);
    import sched_pkg::*;

    logic [31:0] cnt_r;
    logic        oper_d_r;

    // ------------------------------------------------------------
    // SOF generation
    // ------------------------------------------------------------
    // Entering operational restarts the wait; SOF repeats each frame
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_r    <= 32'h0;
            oper_d_r <= 1'b0;
            sof_r    <= 1'b0;
        end else begin
            oper_d_r <= operational;
            sof_r    <= 1'b0;
            if (!operational || !oper_d_r) begin
                cnt_r <= 32'(START_CYC - 1);       // R14
            end else if (cnt_r == 32'h0) begin
                cnt_r <= 32'(FRAME_CYC - 1);
                sof_r <= 1'b1;                     // R14
            end else begin
                cnt_r <= cnt_r - 32'h1;
            end
        end
    end

    a_sof_spacing: assert property (@(posedge clk_sys) disable iff (reset)
        sof_r |=> !sof_r) else $error("SOF pulses back to back"); // R14
endmodule : frame_timer

`default_nettype wire

// ===== design/ratio_arbiter.sv
`default_nettype none

module ratio_arbiter (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [1:0] ratio,
    input  wire logic       ctrl_ok,
    input  wire logic       bulk_ok,
    input  wire logic       ctrl_served,
    input  wire logic       bulk_served,
    output logic            pick_ctrl,
    output logic            pick_bulk,
    output logic [2:0]      count
);
    import sched_pkg::*;

    logic [2:0] count_r;
    logic [2:0] limit;
    logic       ctrl_due;

    // ------------------------------------------------------------
    // Control to bulk choice
    // ------------------------------------------------------------
    // Code n allows n+1 control services per bulk service
    assign limit     = {1'b0, ratio} + 3'h1;           // R12
    assign ctrl_due  = ctrl_ok && (count_r < limit);   // R10
    assign pick_ctrl = ctrl_due || (ctrl_ok && !bulk_ok);
    assign pick_bulk = bulk_ok && !ctrl_due;           // R15
    assign count     = count_r;

    // Count has no frame input, so it carries over frame boundaries
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_r <= 3'h0;
        end else if (bulk_served) begin
            count_r <= 3'h0;                           // R15
        end else if (ctrl_served && count_r < limit) begin
            count_r <= count_r + 3'h1;                 // R11
        end
    end

    a_bulk_clears: assert property (@(posedge clk_sys) disable iff (reset)
        bulk_served |=> count_r == 3'h0) else $error("Count not cleared by bulk"); // R15
endmodule : ratio_arbiter

`default_nettype wire

// ===== design/list_sched_ctrl.sv
`default_nettype none

module list_sched_ctrl #(
    parameter int START_CYC = sched_pkg::SOF_DELAY_CYC,
    parameter int FRAME_CYC = sched_pkg::FRAME_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire logic               operational,
    input  wire logic               ctrl_nonempty,
    input  wire logic               bulk_nonempty,
    input  wire logic               desc_ack,
    input  wire logic               desc_iso,
    input  wire logic               desc_last,
    input  wire logic               ptr_upd,
    input  wire logic [31:0]        ptr_upd_val,
    output var  logic               sched_req,
    output var  sched_pkg::list_t   sched_list,
    output var  logic               iso_allow,
    output var  logic [31:0]        current_ctrl_desc_ptr,
    output logic                    sof
);
    import sched_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0]  ctrl_bulk_ratio_r;
    logic        periodic_list_en_r;
    logic        iso_en_r;
    logic        ctrl_list_en_r;
    logic [27:0] ptr_r;
    logic        iso_frame_r;
    logic        ctrl_armed_r;
    logic        sof_seen_r;
    state_t      state_r;
    state_t      state_nxt;
    logic        req_r;
    list_t       list_r;
    logic        ready_r;
    logic [31:0] rdata_r;
    logic        err_r;
    logic        access;
    logic        wr_done;
    logic        mapped;
    logic        frame_start;
    logic        ctrl_ok;
    logic        pick_ctrl;
    logic        pick_bulk;
    logic [2:0]  ctrl_count;
    logic        ctrl_served;
    logic        bulk_served;
    logic        iso_stop;
    logic        issue;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    frame_timer #(
        .START_CYC (START_CYC),
        .FRAME_CYC (FRAME_CYC)
    ) u_frame_timer (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .operational (operational),
        .sof_r       (sof)
    );

    ratio_arbiter u_ratio_arbiter (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .ratio       (ctrl_bulk_ratio_r),
        .ctrl_ok     (ctrl_ok),
        .bulk_ok     (bulk_nonempty),
        .ctrl_served (ctrl_served),
        .bulk_served (bulk_served),
        .pick_ctrl   (pick_ctrl),
        .pick_bulk   (pick_bulk),
        .count       (ctrl_count)
    );

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign access  = psel && penable;
    assign wr_done = access && ready_r && pwrite;
    assign mapped  = (paddr == ADDR_LIST_CTRL) || (paddr == ADDR_CUR_PTR) ||
                     (paddr == ADDR_SCHED_STAT);

    assign ctrl_word = {27'h0, ctrl_list_en_r, iso_en_r, periodic_list_en_r, ctrl_bulk_ratio_r};
    assign stat_word = {22'h0, ctrl_count, state_r, sof_seen_r, ctrl_armed_r, iso_frame_r};

    // Answer and read data are registered together
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ready_r <= 1'b0;
            rdata_r <= 32'h0;
            err_r   <= 1'b0;
        end else begin
            ready_r <= access && !ready_r;
            err_r   <= access && !ready_r && !mapped;
            if (access && !ready_r) begin
                unique case (paddr)
                    ADDR_LIST_CTRL:  rdata_r <= ctrl_word;
                    ADDR_CUR_PTR:    rdata_r <= {ptr_r, 4'h0};
                    ADDR_SCHED_STAT: rdata_r <= stat_word;
                    default:         rdata_r <= 32'h0;
                endcase
            end
        end
    end

    assign pready  = ready_r;
    assign prdata  = rdata_r;
    assign pslverr = err_r;

    // Control fields; ratio returns to 1:1 on any reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_bulk_ratio_r  <= RATIO_RST;               // R13
            periodic_list_en_r <= 1'b0;
            iso_en_r           <= 1'b0;
            ctrl_list_en_r     <= 1'b0;
        end else if (wr_done && paddr == ADDR_LIST_CTRL) begin
            ctrl_bulk_ratio_r  <= pwdata[RATIO_LSB +: 2];  // R12
            periodic_list_en_r <= pwdata[PERIODIC_BIT];
            iso_en_r           <= pwdata[ISO_BIT];
            ctrl_list_en_r     <= pwdata[CTRL_BIT];
        end
    end

    // Engine update of the pointer wins over a software write
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ptr_r <= PTR_RST;
        end else if (ptr_upd) begin
            ptr_r <= ptr_upd_val[31:PTR_LSB];
        end else if (wr_done && paddr == ADDR_CUR_PTR) begin
            ptr_r <= pwdata[31:PTR_LSB];                   // R3
        end
    end

    assign current_ctrl_desc_ptr = {ptr_r, 4'h0};

    // ------------------------------------------------------------
    // Frame bookkeeping
    // ------------------------------------------------------------
    // A frame starts only when no request is in flight, so an SOF
    // during a descriptor is held until the engine answers
    assign frame_start = (sof || sof_seen_r) && !req_r;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sof_seen_r <= 1'b0;
        end else if (sof) begin
            sof_seen_r <= !frame_start;
        end else if (frame_start) begin
            sof_seen_r <= 1'b0;
        end
    end

    // Iso enable copied only at frame start
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            iso_frame_r <= 1'b0;
        end else if (frame_start) begin
            iso_frame_r <= iso_en_r;                       // R7
        end
    end

    // A newly set control enable waits for the next frame start
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_armed_r <= 1'b0;
        end else if (!ctrl_list_en_r) begin
            ctrl_armed_r <= 1'b0;                          // R4
        end else if (frame_start) begin
            ctrl_armed_r <= 1'b1;                          // R1
        end
    end

    // Live enable checked on every control decision
    assign ctrl_ok = ctrl_list_en_r && ctrl_armed_r && ctrl_nonempty; // R2

    // ------------------------------------------------------------
    // List walk state machine
    // ------------------------------------------------------------
    assign iso_stop    = desc_ack && list_r == LIST_PERIODIC && desc_iso && !iso_frame_r; // R6
    assign ctrl_served = desc_ack && list_r == LIST_CTRL;
    assign bulk_served = desc_ack && list_r == LIST_BULK;
    assign issue       = !req_r && !frame_start &&
                         (state_r == ST_PER || (state_r == ST_NPER && (pick_ctrl || pick_bulk)));

    always_comb begin
        state_nxt = state_r;
        if (frame_start) begin
            state_nxt = periodic_list_en_r ? ST_PER : ST_NPER;  // R9
        end else begin
            unique case (state_r)
                ST_IDLE: state_nxt = ST_IDLE;
                ST_PER: begin
                    if (iso_stop || (desc_ack && desc_last)) begin
                        state_nxt = ST_NPER;                    // R5
                    end
                end
                ST_NPER: begin
                    if (!req_r && !pick_ctrl && !pick_bulk) begin
                        state_nxt = ST_DONE;                    // R10
                    end
                end
                ST_DONE: state_nxt = ST_DONE;
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;                              // R8
        end
    end

    // Request stands until the engine acknowledges it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            req_r  <= 1'b0;
            list_r <= LIST_PERIODIC;
        end else if (desc_ack) begin
            req_r <= 1'b0;
        end else if (issue) begin
            req_r <= 1'b1;
            if (state_r == ST_PER) begin
                list_r <= LIST_PERIODIC;
            end else if (pick_ctrl) begin
                list_r <= LIST_CTRL;                           // R10
            end else begin
                list_r <= LIST_BULK;                           // R15
            end
        end
    end

    assign sched_req  = req_r;
    assign sched_list = list_r;
    assign iso_allow  = iso_frame_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_ctrl_off;
        !ctrl_list_en_r;
    endsequence

    sequence s_ctrl_issue;
        issue && pick_ctrl && state_r == ST_NPER;
    endsequence

    a_ctrl_gate: assert property (@(posedge clk_sys) disable iff (reset)
        s_ctrl_off |-> not s_ctrl_issue) else $error("Control issued while disabled"); // R4

    a_ctrl_live: assert property (@(posedge clk_sys) disable iff (reset)
        req_r && list_r == LIST_CTRL && $rose(req_r) |-> $past(ctrl_list_en_r)) else $error("Control without enable"); // R2

    a_ctrl_next_frame: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(ctrl_list_en_r) && !frame_start |=> !ctrl_armed_r) else $error("Control armed mid frame"); // R1

    a_iso_frame: assert property (@(posedge clk_sys) disable iff (reset)
        !frame_start |=> $stable(iso_frame_r)) else $error("Iso copy changed mid frame"); // R7

    a_iso_halt: assert property (@(posedge clk_sys) disable iff (reset)
        iso_stop && !frame_start && state_r == ST_PER |=> state_r == ST_NPER) else $error("Iso halt ignored"); // R6

    a_iso_go: assert property (@(posedge clk_sys) disable iff (reset)
        state_r == ST_PER && desc_ack && desc_iso && iso_frame_r && !desc_last && !frame_start
        |=> state_r == ST_PER) else $error("Iso walk stopped"); // R5

    a_per_start: assert property (@(posedge clk_sys) disable iff (reset)
        frame_start |=> (state_r == ST_PER) == $past(periodic_list_en_r)) else $error("Periodic start wrong"); // R9

    a_per_off: assert property (@(posedge clk_sys) disable iff (reset)
        frame_start && !periodic_list_en_r |=> state_r != ST_PER [*2]) else $error("Periodic after disable"); // R8

    a_ratio_pick: assert property (@(posedge clk_sys) disable iff (reset)
        ctrl_ok && bulk_nonempty && ctrl_count > {1'b0, ctrl_bulk_ratio_r} |-> pick_bulk && !pick_ctrl)
        else $error("Ratio limit ignored"); // R10

    a_count_frame: assert property (@(posedge clk_sys) disable iff (reset)
        frame_start && !desc_ack |=> $stable(ctrl_count)) else $error("Count lost at frame"); // R11

    a_ratio_reset: assert property (@(posedge clk_sys)
        $fell(reset) |-> ctrl_bulk_ratio_r == RATIO_RST) else $error("Ratio not reset"); // R13

    a_req_hold: assert property (@(posedge clk_sys) disable iff (reset)
        req_r && !desc_ack |=> req_r && $stable(list_r)) else $error("Request dropped"); // R14

    a_apb_wait: assert property (@(posedge clk_sys) disable iff (reset)
        access && !ready_r |=> ready_r) else $error("APB answer late"); // R12
endmodule : list_sched_ctrl

`default_nettype wire

// ===== testbench/testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sched_pkg::*;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    localparam int START = 50;
    localparam int FRAME = 200;
    localparam int LIMIT = 20000;

    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } row_t;

    logic        clk_sys = 1'b0;
    logic        reset, psel, penable, pwrite, operational;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ptr_upd_val, current_ctrl_desc_ptr, rd;
    logic        pready, pslverr, ctrl_nonempty, bulk_nonempty, ptr_upd, err;
    logic        desc_ack = 1'b0;
    logic        desc_iso = 1'b0;
    logic        desc_last = 1'b0;
    logic        sched_req, iso_allow, sof;
    logic        iso_desc, last_desc;
    list_t       sched_list;
    logic [1:0]  seen[$];
    int          frame_mark, bad_count, samples_checked, cycles, n, i;
    row_t        rows[9] = '{
        '{1'b0, 12'h008, 32'h0, 32'h8, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h000, 32'h1f, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'h1f, 1'b0},
        '{1'b1, 12'h004, 32'h12345678, 32'h0, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'h12345670, 1'b0},
        '{1'b1, 12'h00c, 32'hffffffff, 32'h0, 1'b1},
        '{1'b0, 12'h00c, 32'h0, 32'h0, 1'b1}};

    list_sched_ctrl #(.START_CYC(START), .FRAME_CYC(FRAME)) list_sched_ctrl_inst (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .operational(operational), .ctrl_nonempty(ctrl_nonempty), .bulk_nonempty(bulk_nonempty),
        .desc_ack(desc_ack), .desc_iso(desc_iso), .desc_last(desc_last), .ptr_upd(ptr_upd),
        .ptr_upd_val(ptr_upd_val), .sched_req(sched_req), .sched_list(sched_list),
        .iso_allow(iso_allow), .current_ctrl_desc_ptr(current_ctrl_desc_ptr), .sof(sof));

    // Clock and cycle ceiling, a hang ends in the report
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            test_done();
        end
    end

    // Engine stand-in: answers each request one cycle later and logs the list served
    always @(posedge clk_sys) begin
        if (desc_ack) begin
            desc_ack <= 1'b0;
        end else if (sched_req === 1'b1) begin
            desc_ack  <= 1'b1;
            desc_iso  <= iso_desc;
            desc_last <= last_desc;
            seen.push_back(sched_list);
        end
        // Mark after logging: a request in flight at SOF belongs to the old frame
        if (sof === 1'b1) frame_mark = seen.size();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic chk_at(input int idx, input logic [1:0] exp);
        logic [1:0] got;
        got = (idx < seen.size()) ? seen[idx] : 2'h3;  // Missing entry reads as no list
        chk({30'h0, got}, {30'h0, exp}, "list served");
    endtask : chk_at

    // APB transfer: setup, access held until pready, then an idle edge so signals never clash
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge clk_sys);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (w >= 50) chk(32'h0, 32'h1, "apb wait");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wait_sof();
        int w;
        w = 0;
        do begin
            @(posedge clk_sys);
            w++;
        end while (sof !== 1'b1 && w < 2 * FRAME);
        if (sof !== 1'b1) chk(32'h0, 32'h1, "no frame start");
        @(posedge clk_sys);
    endtask : wait_sof

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; operational = 1'b0; ctrl_nonempty = 1'b0;
        bulk_nonempty = 1'b0; ptr_upd = 1'b0; ptr_upd_val = 32'h0; iso_desc = 1'b0;
        last_desc = 1'b1;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        // Register table rows: reset values, read-back, unmapped refusal
        foreach (rows[k]) begin
            apb(rows[k].wr, rows[k].addr, rows[k].wdata);
            if (!rows[k].wr) chk(rd, rows[k].rdata, "read data");
            chk({31'h0, err}, {31'h0, rows[k].err}, "slave error");
        end
        chk(current_ctrl_desc_ptr, 32'h12345670, "pointer port");
        // First frame only after the start delay; nothing requested before it
        apb(1'b1, 12'h000, 32'h10);
        ctrl_nonempty <= 1'b1;
        bulk_nonempty <= 1'b1;
        operational   <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (sof !== 1'b1 && n < 1000);
        // Pulse is launched START+1 edges after the rise and seen at the edge after that
        chk(n, START + 2, "first frame start");
        chk(frame_mark, 0, "request before first frame");
        // Every ratio code: between two bulk services come exactly r+1 control services
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, 12'h000, 32'h10 | r);
            wait_sof();
            repeat (60) @(posedge clk_sys);
            i = frame_mark;
            while (i < seen.size() && seen[i] != LIST_BULK) i++;
            for (int c = 1; c <= r + 1; c++) chk_at(i + c, LIST_CTRL);
            chk_at(i + r + 2, LIST_BULK);
        end
        // Control disabled: no control service after the next frame start
        bulk_nonempty <= 1'b0;
        apb(1'b1, 12'h000, 32'h0);
        wait_sof();
        repeat (40) @(posedge clk_sys);
        chk(seen.size() - frame_mark, 0, "served while disabled");
        // Pointer moved before control is enabled again; service waits for the frame
        apb(1'b1, 12'h004, 32'h00000a50);
        apb(1'b1, 12'h000, 32'h10);
        n = seen.size();
        wait_sof();
        chk(frame_mark - n, 0, "served before frame");
        repeat (20) @(posedge clk_sys);
        chk_at(frame_mark, LIST_CTRL);
        chk(current_ctrl_desc_ptr, 32'h00000a50, "pointer write");
        // Engine pointer update drops the low nibble
        ptr_upd     <= 1'b1;
        ptr_upd_val <= 32'habcdef1f;
        @(posedge clk_sys);
        ptr_upd <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(current_ctrl_desc_ptr, 32'habcdef10, "pointer update");
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'habcdef10, "pointer read");
        // Periodic with iso off: one iso descriptor ends the walk, control follows
        iso_desc  <= 1'b1;
        last_desc <= 1'b0;
        apb(1'b1, 12'h000, 32'h14);
        wait_sof();
        repeat (20) @(posedge clk_sys);
        chk_at(frame_mark, LIST_PERIODIC);
        chk_at(frame_mark + 1, LIST_CTRL);
        // Iso enabled mid-frame acts only from the next frame
        apb(1'b1, 12'h000, 32'h1c);
        chk({31'h0, iso_allow}, 32'h0, "iso in current frame");
        wait_sof();
        repeat (3) @(posedge clk_sys);
        chk({31'h0, iso_allow}, 32'h1, "iso next frame");
        repeat (20) @(posedge clk_sys);
        for (int c = 0; c < 3; c++) chk_at(frame_mark + c, LIST_PERIODIC);
        last_desc <= 1'b1;
        // Periodic disabled: none after the next frame start
        apb(1'b1, 12'h000, 32'h10);
        wait_sof();
        repeat (20) @(posedge clk_sys);
        n = 0;
        for (int c = frame_mark; c < seen.size(); c++) if (seen[c] == LIST_PERIODIC) n++;
        chk(n, 0, "periodic while disabled");
        // Mid-run reset: ratio falls back to 1:1 and the scheduler idles until SOF
        apb(1'b1, 12'h000, 32'h13);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk({31'h0, sched_req}, 32'h0, "request after reset");
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0, "ratio after reset");
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h8, "status after reset");
        test_done();
    end
endmodule : testbench

`default_nettype wire
